// ---- rtl/tcc_cfg.svh ----
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TCC_ADDR_CTRL 6'h00
`define TCC_ADDR_COUNT 6'h04
`define TCC_ADDR_CMP 6'h08
`define TCC_ADDR_STAT 6'h0c
`define TCC_ADDR_IEN 6'h10
`define TCC_ADDR_FORCE 6'h14
`define TCC_ADDR_ACT 6'h18
// ----------------------------------------
// control field positions
// ----------------------------------------
`define TCC_WGM_LO 0
`define TCC_WGM_HI 1
`define TCC_COM_LO 2
`define TCC_COM_HI 3
`define TCC_CS_LO 4
`define TCC_CS_HI 6
`define TCC_ASYNC_BIT 7
// ----------------------------------------
// status and enable bits
// ----------------------------------------
`define TCC_CMP_BIT 0
`define TCC_OVF_BIT 1
`define TCC_BOT_BIT 2
`define TCC_TOP_BIT 3
// ----------------------------------------
// values
// ----------------------------------------
`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hff
`define TCC_RST8 8'h00
`define TCC_CS_OFF 3'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3
`define TCC_RESP_OK 2'h0
`define TCC_RESP_DECERR 2'h3
`define TCC_PRE_W 12
`endif

// ---- rtl/tcc_pkg.sv ----
package tcc_pkg;
  // waveform modes in field order
  typedef enum logic [1:0] {
    tcc_normal,
    tcc_pwm_phase,
    tcc_clear_on_match,
    tcc_pwm_fast
  } tcc_mode_type;
endpackage : tcc_pkg

// ---- rtl/tcc_timer.sv ----
// Behaviour
// R1: each timer tick clears, increments or decrements the counter per mode
// R2: count moves one step by direction; clear zeroes all counter bits
// R3: bottom flag at zero, top flag at the sequence's highest value
// R4: clock select zero stops ticks and freezes the counter
// R5: counter is readable and writable at any time
// R6: software counter write beats any clear or count that cycle
// R7: two waveform mode bits select the counting sequence
// R8: overflow flag set at a mode dependent point, usable as interrupt
// R9: 8-bit comparator flags counter equal to active compare value
// R10: a match sets the compare flag one timer tick later
// R11: compare interrupt requested when flag set and enable is one
// R12: compare flag clears on service or on software write of one
// R13: output action depends on match, waveform mode and output mode
// R14: top and bottom indications drive the pwm output corner cases
// R15: compare value double buffered in pwm modes, direct otherwise
// R16: buffered compare copied to active only at sequence top
// R17: compare accesses reach buffer when buffered, active otherwise
// R18: force strobe in non-pwm modes acts on output only
// R19: counter write blocks compare matches on the next timer tick
// R20: software avoids writing count equal to compare or zero downcounting
// R21: software sets up compare output before enabling the pin
// R22: compare output state survives waveform mode changes
// R23: output mode field takes effect immediately, not buffered
// R24: bottom is 0x00, max 0xff, top is max or compare per mode
// R25: timer ticks come from system clock or oscillator ticks by select
// R26: normal mode counts up, wraps, overflow flag as count becomes zero
// R27: clear-on-match mode clears counter when it matches compare
// R28: hardware set of compare flag wins over a same cycle clear
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`include "tcc_cfg.svh"
module tcc_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_tick,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic compare_output,
  output logic compare_irq,
  output logic overflow_irq,
  output logic counter_at_bottom,
  output logic counter_at_top
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] timer_count_value_r;
  logic [7:0] compare_buffer_r;
  logic [7:0] compare_value_register_r;
  logic compare_match_flag_r;
  logic overflow_flag_r;
  logic [1:0] irq_en_r;
  logic count_up_r;
  logic block_r;
  logic out_r;
  logic [`TCC_PRE_W-1:0] pre_r;
  logic [5:0] awaddr_r;
  logic aw_full_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  tcc_pkg::tcc_mode_type mode;
  logic [1:0] com;
  logic [2:0] cs;
  logic is_pwm;
  logic wr_go;
  logic wr_b0;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_stat;
  logic wr_ien;
  logic wr_force;
  logic src_tick;
  logic tick;
  logic match;
  logic hit;
  logic at_max;
  logic at_top;
  logic at_bot;
  logic ovf_hit;
  logic force_go;
  logic [7:0] cnt_nxt;
  logic dir_nxt;
  logic out_nxt;
  logic [31:0] rd_nxt;
  logic rd_ok;

  assign mode = tcc_pkg::tcc_mode_type'(ctrl_r[`TCC_WGM_HI:`TCC_WGM_LO]); // R7
  assign com = ctrl_r[`TCC_COM_HI:`TCC_COM_LO]; // R23
  assign cs = ctrl_r[`TCC_CS_HI:`TCC_CS_LO];
  assign is_pwm = (mode == tcc_pkg::tcc_pwm_phase) || (mode == tcc_pkg::tcc_pwm_fast);

  // prescaler mask: divide by four to the power cs-1
  function automatic logic [`TCC_PRE_W-1:0] pre_mask(input logic [2:0] sel);
    logic [`TCC_PRE_W:0] one;
    one = {{`TCC_PRE_W{1'b0}}, 1'b1} << {sel - 3'h1, 1'b0};
    pre_mask = one[`TCC_PRE_W-1:0] - {{(`TCC_PRE_W-1){1'b0}}, 1'b1};
  endfunction : pre_mask

  // non-pwm output action, shared by real and forced matches
  function automatic logic non_pwm_out(input logic [1:0] m, input logic cur);
    case (m)
      `TCC_COM_TOGGLE: non_pwm_out = !cur;
      `TCC_COM_CLEAR: non_pwm_out = 1'b0;
      `TCC_COM_SET: non_pwm_out = 1'b1;
      default: non_pwm_out = cur;
    endcase
  endfunction : non_pwm_out

  // ----------------------------------------
  // timer tick generation
  // ----------------------------------------
  // oscillator ticks arrive as enables already in this clock domain
  assign src_tick = ctrl_r[`TCC_ASYNC_BIT] ? osc_tick : 1'b1; // R25
  assign tick = (cs != `TCC_CS_OFF) && src_tick
      && ((pre_r & pre_mask(cs)) == pre_mask(cs)); // R4

  // prescaler held at zero while stopped so restart is phase aligned
  always_ff @(posedge aclk) begin
    if (!aresetn || cs == `TCC_CS_OFF) begin
      pre_r <= '0;
    end else if (src_tick) begin
      pre_r <= pre_r + {{(`TCC_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // counter unit
  // ----------------------------------------
  assign at_max = timer_count_value_r == `TCC_MAX; // R24
  assign at_bot = timer_count_value_r == `TCC_BOTTOM; // R24
  assign at_top = (mode == tcc_pkg::tcc_clear_on_match) ? match : at_max; // R3
  assign match = timer_count_value_r == compare_value_register_r; // R9
  assign hit = match && !block_r; // R19
  assign counter_at_bottom = at_bot; // R3
  assign counter_at_top = at_top; // R3

  // next count per mode; phase mode turns round at max and bottom
  always_comb begin
    cnt_nxt = timer_count_value_r + 8'h01; // R2
    dir_nxt = 1'b1;
    case (mode)
      tcc_pkg::tcc_clear_on_match: begin
        if (hit) begin
          cnt_nxt = `TCC_BOTTOM; // R27
        end
      end
      tcc_pkg::tcc_pwm_phase: begin
        dir_nxt = count_up_r ? !at_max : at_bot; // R14
        if (!dir_nxt) begin
          cnt_nxt = timer_count_value_r - 8'h01; // R2
        end
      end
      default: begin
        dir_nxt = 1'b1; // R26
      end
    endcase
  end

  // software write wins over any tick action
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_value_r <= `TCC_RST8;
      count_up_r <= 1'b1;
    end else if (wr_count) begin
      timer_count_value_r <= wdata_r[7:0]; // R5 R6
    end else if (tick) begin
      timer_count_value_r <= cnt_nxt; // R1
      count_up_r <= dir_nxt;
    end
  end

  // a counter write blocks matches until the next tick has passed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_r <= 1'b0;
    end else if (wr_count) begin
      block_r <= 1'b1; // R19
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // compare registers
  // ----------------------------------------
  // pwm writes land in the buffer; copied at top to avoid odd pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_buffer_r <= `TCC_RST8;
      compare_value_register_r <= `TCC_RST8;
    end else begin
      if (wr_cmp) begin
        compare_buffer_r <= wdata_r[7:0]; // R17
      end
      if (wr_cmp && !is_pwm) begin
        compare_value_register_r <= wdata_r[7:0]; // R15
      end else if (is_pwm && tick && at_max) begin
        compare_value_register_r <= compare_buffer_r; // R16
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign ovf_hit = (mode == tcc_pkg::tcc_pwm_phase) ? (at_bot && !count_up_r) : at_max; // R8

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_match_flag_r <= 1'b0;
    end else if (tick && hit) begin
      compare_match_flag_r <= 1'b1; // R10 R28
    end else if (compare_irq_ack || (wr_stat && wdata_r[`TCC_CMP_BIT])) begin
      compare_match_flag_r <= 1'b0; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_r <= 1'b0;
    end else if (tick && ovf_hit && !wr_count) begin
      overflow_flag_r <= 1'b1; // R26
    end else if (overflow_irq_ack || (wr_stat && wdata_r[`TCC_OVF_BIT])) begin
      overflow_flag_r <= 1'b0;
    end
  end

  assign compare_irq = compare_match_flag_r && irq_en_r[`TCC_CMP_BIT]; // R11
  assign overflow_irq = overflow_flag_r && irq_en_r[`TCC_OVF_BIT]; // R8

  // ----------------------------------------
  // waveform output
  // ----------------------------------------
  assign force_go = wr_force && wdata_r[0] && !is_pwm;

  // output mode read live each time; mode changes never reset the output
  always_comb begin
    out_nxt = out_r; // R22
    if (tick) begin
      case (mode)
        tcc_pkg::tcc_pwm_fast: begin
          if (hit && com[1]) begin
            out_nxt = com[0]; // R13
          end else if (at_max && com[1]) begin
            out_nxt = !com[0]; // R14
          end
        end
        tcc_pkg::tcc_pwm_phase: begin
          if (hit && com[1]) begin
            out_nxt = count_up_r ? com[0] : !com[0]; // R13
          end
        end
        default: begin
          if (hit) begin
            out_nxt = non_pwm_out(com, out_r); // R13 R23
          end
        end
      endcase
    end
    if (force_go) begin
      out_nxt = non_pwm_out(com, out_r); // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign compare_output = out_r;

  // ----------------------------------------
  // bus slave, write side
  // ----------------------------------------
  // address and data are held until both are in, then applied once
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign wr_b0 = wr_go && wstrb_r[0];
  assign wr_ctrl = wr_b0 && awaddr_r == `TCC_ADDR_CTRL;
  assign wr_count = wr_b0 && awaddr_r == `TCC_ADDR_COUNT;
  assign wr_cmp = wr_b0 && awaddr_r == `TCC_ADDR_CMP;
  assign wr_stat = wr_b0 && awaddr_r == `TCC_ADDR_STAT;
  assign wr_ien = wr_b0 && awaddr_r == `TCC_ADDR_IEN;
  assign wr_force = wr_b0 && awaddr_r == `TCC_ADDR_FORCE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[5:2], 2'b00};
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `TCC_RESP_OK;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r > `TCC_ADDR_ACT) ? `TCC_RESP_DECERR : `TCC_RESP_OK;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // control and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `TCC_RST8;
      irq_en_r <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[7:0];
      end
      if (wr_ien) begin
        irq_en_r <= wdata_r[1:0];
      end
    end
  end

  // ----------------------------------------
  // bus slave, read side
  // ----------------------------------------
  // compare reads follow the same buffer choice as writes
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `TCC_ADDR_CTRL: rd_nxt[7:0] = ctrl_r;
      `TCC_ADDR_COUNT: rd_nxt[7:0] = timer_count_value_r; // R5
      `TCC_ADDR_CMP: rd_nxt[7:0] = is_pwm ? compare_buffer_r : compare_value_register_r; // R17
      `TCC_ADDR_STAT: begin
        rd_nxt[`TCC_CMP_BIT] = compare_match_flag_r;
        rd_nxt[`TCC_OVF_BIT] = overflow_flag_r;
        rd_nxt[`TCC_BOT_BIT] = at_bot;
        rd_nxt[`TCC_TOP_BIT] = at_top;
      end
      `TCC_ADDR_IEN: rd_nxt[1:0] = irq_en_r;
      `TCC_ADDR_FORCE: rd_nxt[0] = 1'b0; // strobe reads as zero
      `TCC_ADDR_ACT: rd_nxt[7:0] = compare_value_register_r;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `TCC_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_nxt;
      rresp_r <= rd_ok ? `TCC_RESP_OK : `TCC_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  stop_no_tick_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    cs == `TCC_CS_OFF |-> !tick) else $error("tick while stopped");

  write_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    wr_count |=> timer_count_value_r == $past(wdata_r[7:0]))
    else $error("counter write lost");

  ctc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R27
    tick && hit && !wr_count && mode == tcc_pkg::tcc_clear_on_match
    |=> timer_count_value_r == `TCC_BOTTOM) else $error("no clear on match");

  normal_up_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    tick && !wr_count && !wr_ctrl && mode == tcc_pkg::tcc_normal
    |=> timer_count_value_r == $past(timer_count_value_r) + 8'h01)
    else $error("normal count not one up");

  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    tick && match && !block_r |=> compare_match_flag_r) else $error("match flag not set");

  match_block_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    wr_count ##1 (tick && !compare_match_flag_r) |=> !compare_match_flag_r)
    else $error("match after counter write");

  cmp_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    $rose(compare_match_flag_r) && irq_en_r[`TCC_CMP_BIT] |-> compare_irq)
    else $error("no compare irq");

  ovf_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // R26
    tick && at_max && !wr_count && !wr_ctrl && mode == tcc_pkg::tcc_normal
    |=> overflow_flag_r && timer_count_value_r == `TCC_BOTTOM)
    else $error("no overflow at wrap");

  buffer_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    is_pwm && !wr_ctrl && !(tick && at_max)
    |=> $stable(compare_value_register_r)) else $error("active compare moved off top");

  force_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    force_go && com == `TCC_COM_TOGGLE
    |=> compare_output != $past(compare_output) && $stable(compare_match_flag_r))
    else $error("force strobe misbehaved");
endmodule : tcc_timer

// ---- sim/tcc_cpu_model.sv ----
// ----------------------------------------
// processor side: axi4-lite master and irq service
// ----------------------------------------
module tcc_cpu_model (
  input wire logic aclk,
  output logic [5:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [5:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic cmp_ack,
  output logic ovf_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cmp_ack, ovf_ack} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
  end
  // both halves offered together; released halves show inverted payload
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] resp, output bit ok);
    int n;
    bit aw_ok;
    bit w_ok;
    ok = 0;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 64 && !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_ok = 1;
      end
      if (!w_ok && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_ok = 1;
      end
    end
    bready <= 1'b1;
    for (n = 0; n < 64 && !ok && aw_ok && w_ok; n++) begin
      @(posedge aclk);
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        ok = 1;
      end
    end
  endtask : wr
  // read held until arready, rready held until rvalid seen
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp,
      output bit ok);
    int n;
    bit ar_ok;
    ok = 0;
    ar_ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (ar_ok && rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        ok = 1;
      end
      if (!ar_ok && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
        ar_ok = 1;
      end
    end
  endtask : rd
  // one-cycle interrupt service pulse
  task automatic ack(input bit ovf);
    @(posedge aclk);
    if (ovf) ovf_ack <= 1'b1;
    else cmp_ack <= 1'b1;
    @(posedge aclk);
    cmp_ack <= 1'b0;
    ovf_ack <= 1'b0;
  endtask : ack
endmodule : tcc_cpu_model

// ---- sim/tb_tcc_timer.sv ----
`include "tcc_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_tcc_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, osc_tick, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmp_ack, ovf_ack;
  logic compare_output, compare_irq, overflow_irq, counter_at_bottom, counter_at_top;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int checked = 0;
  int n_fail = 0;
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  tcc_timer tcc_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_tick(osc_tick), .compare_irq_ack(cmp_ack),
    .overflow_irq_ack(ovf_ack), .compare_output(compare_output),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq),
    .counter_at_bottom(counter_at_bottom), .counter_at_top(counter_at_top));
  tcc_cpu_model tcc_cpu_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cmp_ack(cmp_ack), .ovf_ack(ovf_ack));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // a bus hang ends the run at once
  task automatic hang();
    n_fail++;
    $display("ERROR t=%0t bus handshake timed out", $time);
    tally_and_finish();
  endtask : hang
  // control byte: async source always selected so ticks are under bench control
  function automatic logic [7:0] ctl(logic [1:0] m, logic [1:0] com, logic [2:0] cs);
    return {1'b1, cs, com, m};
  endfunction : ctl
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf,
      input logic [1:0] er = `TCC_RESP_OK);
    logic [1:0] r;
    bit ok;
    tcc_cpu_model_i.wr(a, {24'h0, d}, s, r, ok);
    if (!ok) hang();
    @(negedge aclk);
    `CHK(r, er)
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffffffff, input logic [1:0] er = `TCC_RESP_OK);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    tcc_cpu_model_i.rd(a, d, r, ok);
    if (!ok) hang();
    @(negedge aclk);
    `CHK(d & m, e)
    `CHK(r, er)
  endtask : rd
  // oscillator pulses spaced so each one lands well apart
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      osc_tick <= 1'b1;
      @(posedge aclk);
      osc_tick <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    @(negedge aclk);
  endtask : tick
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    osc_tick = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(counter_at_bottom, 1'b1)
    for (int i = 0; i < 7; i++) rd(6'(i * 4), (i == 3) ? 32'h4 : 32'h0);
    rd(6'h1c, 32'h0, 32'h0, `TCC_RESP_DECERR);
    wr(6'h1c, 8'h01, 4'hf, `TCC_RESP_DECERR);
    wr(`TCC_ADDR_CTRL, 8'hff, 4'h0);
    rd(`TCC_ADDR_CTRL, 32'h0);
    // stopped clock select: oscillator pulses change nothing
    wr(`TCC_ADDR_CTRL, ctl(2'h0, 2'h0, 3'h0));
    tick(3);
    rd(`TCC_ADDR_COUNT, 32'h0);
    // normal mode wrap and overflow
    wr(`TCC_ADDR_COUNT, 8'hfd);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, 2'h0, 3'h1));
    tick(2);
    `CHK(counter_at_top, 1'b1)
    rd(`TCC_ADDR_COUNT, 32'hff);
    tick(1);
    rd(`TCC_ADDR_COUNT, 32'h0);
    rd(`TCC_ADDR_STAT, 32'h6);
    wr(`TCC_ADDR_IEN, 8'h02);
    `CHK(overflow_irq, 1'b1)
    tcc_cpu_model_i.ack(1'b1);
    @(negedge aclk);
    `CHK(overflow_irq, 1'b0)
    // compare match one tick late, interrupt, service clear
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_COM_TOGGLE, 3'h1));
    wr(`TCC_ADDR_CMP, 8'h05);
    rd(`TCC_ADDR_ACT, 32'h5);
    wr(`TCC_ADDR_COUNT, 8'h04);
    tick(1);
    rd(`TCC_ADDR_STAT, 32'h0);
    tick(1);
    rd(`TCC_ADDR_STAT, 32'h1);
    `CHK(compare_output, 1'b1)
    wr(`TCC_ADDR_IEN, 8'h03);
    `CHK(compare_irq, 1'b1)
    tcc_cpu_model_i.ack(1'b0);
    @(negedge aclk);
    `CHK(compare_irq, 1'b0)
    // counter written equal to compare on purpose: match must be swallowed
    wr(`TCC_ADDR_COUNT, 8'h05);
    tick(1);
    rd(`TCC_ADDR_STAT, 32'h0);
    `CHK(compare_output, 1'b1)
    wr(`TCC_ADDR_COUNT, 8'h03);
    tick(3);
    rd(`TCC_ADDR_STAT, 32'h1);
    wr(`TCC_ADDR_STAT, 8'h01);
    rd(`TCC_ADDR_STAT, 32'h0);
    `CHK(compare_output, 1'b0)
    // output set up by force in normal mode before any pin use
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_COM_SET, 3'h0));
    wr(`TCC_ADDR_FORCE, 8'h01);
    `CHK(compare_output, 1'b1)
    rd(`TCC_ADDR_STAT, 32'h0);
    rd(`TCC_ADDR_COUNT, 32'h6);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_COM_CLEAR, 3'h0));
    wr(`TCC_ADDR_FORCE, 8'h01);
    `CHK(compare_output, 1'b0)
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_COM_SET, 3'h0));
    wr(`TCC_ADDR_FORCE, 8'h01);
    wr(`TCC_ADDR_CTRL, ctl(2'h2, `TCC_COM_SET, 3'h0));
    `CHK(compare_output, 1'b1)
    // forced toggle flips the output and leaves the flag alone
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_COM_TOGGLE, 3'h0));
    wr(`TCC_ADDR_FORCE, 8'h01);
    `CHK(compare_output, 1'b0)
    rd(`TCC_ADDR_STAT, 32'h0);
    // clear-on-match: compare value is the top
    wr(`TCC_ADDR_CTRL, ctl(2'h2, 2'h0, 3'h1));
    wr(`TCC_ADDR_CMP, 8'h03);
    wr(`TCC_ADDR_COUNT, 8'h00);
    tick(3);
    `CHK(counter_at_top, 1'b1)
    tick(1);
    rd(`TCC_ADDR_COUNT, 32'h0);
    // fast pwm: compare writes land in the buffer until max
    wr(`TCC_ADDR_CTRL, ctl(2'h3, 2'h0, 3'h0));
    wr(`TCC_ADDR_CMP, 8'h40);
    rd(`TCC_ADDR_CMP, 32'h40);
    rd(`TCC_ADDR_ACT, 32'h3);
    wr(`TCC_ADDR_COUNT, 8'hfe);
    wr(`TCC_ADDR_CTRL, ctl(2'h3, 2'h0, 3'h1));
    tick(1);
    rd(`TCC_ADDR_ACT, 32'h3);
    tick(1);
    rd(`TCC_ADDR_ACT, 32'h40);
    rd(`TCC_ADDR_COUNT, 32'h0);
    // phase pwm turns round at max
    wr(`TCC_ADDR_CTRL, ctl(2'h1, 2'h0, 3'h0));
    wr(`TCC_ADDR_COUNT, 8'hfd);
    wr(`TCC_ADDR_CTRL, ctl(2'h1, 2'h0, 3'h1));
    tick(3);
    rd(`TCC_ADDR_COUNT, 32'hfe);
    tally_and_finish();
  end
endmodule : tb_tcc_timer
